/* logic/deb_pkg.sv */
// Constants and types shared by the drive error log builder.
// Assumes one device clock and an active-low asynchronous reset.
package deb_pkg;

    // ------------------------------------------------------------------
    // Log addresses and directory contents
    // ------------------------------------------------------------------
    localparam logic [7:0] LOG_DIRECTORY = 8'h00;
    localparam logic [7:0] LOG_ERROR = 8'h03;
    localparam logic [7:0] LOG_NCQ = 8'h10;
    localparam logic [7:0] LOG_LINK_EVENT = 8'h11;
    localparam logic [7:0] LOG_QUEUE_MGMT = 8'h12;
    localparam logic [7:0] LOG_REBUILD = 8'h15;
    localparam logic [7:0] VENDOR_LOG_FIRST = 8'h80;
    localparam logic [7:0] VENDOR_LOG_LAST = 8'h9F;
    localparam logic [7:0] VENDOR_LOG_SECTORS = 8'h10;
    localparam logic [7:0] ERROR_LOG_SECTORS = 8'h01;
    localparam logic [15:0] DIR_VERSION = 16'h0001;

    // ------------------------------------------------------------------
    // Error log sector layout
    // ------------------------------------------------------------------
    localparam logic [7:0] ERR_VERSION = 8'h01;
    localparam logic [8:0] OFS_VERSION = 9'h000;
    localparam logic [8:0] OFS_INDEX_LO = 9'h002;
    localparam logic [8:0] OFS_INDEX_HI = 9'h003;
    localparam logic [8:0] OFS_ENTRY0 = 9'h004;
    localparam logic [8:0] OFS_ENTRY1 = 9'h080;
    localparam logic [8:0] OFS_ENTRY2 = 9'h0FC;
    localparam logic [8:0] OFS_ENTRY3 = 9'h178;
    localparam logic [8:0] OFS_COUNT_LO = 9'h1F4;
    localparam logic [8:0] OFS_COUNT_HI = 9'h1F5;
    localparam logic [8:0] OFS_CHECKSUM = 9'h1FF;
    localparam int ENTRY_BYTES = 124;
    localparam int NUM_ENTRIES = 4;
    localparam int CMD_SNAP_BYTES = 18;
    localparam int NUM_CMD_SNAPS = 5;
    localparam int ERR_SNAP_OFS = 90;
    localparam int CMD_TS_OFS = 14;
    localparam int ERR_STATE_OFS = 31;
    localparam int ERR_HOURS_OFS = 32;
    localparam logic [2:0] MAX_INDEX = 3'h4;
    localparam logic [15:0] ERR_COUNT_MAX = 16'hFFFF;

    // Power state codes carried in the low nibble of the state byte.
    localparam logic [3:0] STATE_UNKNOWN = 4'h0;
    localparam logic [3:0] STATE_SLEEP = 4'h1;
    localparam logic [3:0] STATE_STANDBY = 4'h2;
    localparam logic [3:0] STATE_ACTIVE = 4'h3;
    localparam logic [3:0] STATE_OFFLINE = 4'h4;

    typedef logic [CMD_SNAP_BYTES-1:0][7:0] deb_cmd_snap_t;
    typedef logic [ENTRY_BYTES-1:0][7:0] deb_entry_t;

    typedef enum logic [2:0] {
        DEB_TF_DEVCTL = 3'h0,
        DEB_TF_FEATURES = 3'h1,
        DEB_TF_COUNT = 3'h2,
        DEB_TF_NUMBER = 3'h3,
        DEB_TF_CYL_LO = 3'h4,
        DEB_TF_CYL_HI = 3'h5,
        DEB_TF_DEVHEAD = 3'h6,
        DEB_TF_COMMAND = 3'h7
    } deb_tf_sel_t;

endpackage

/* logic/deb_shadow_if.sv */
// Interface carrying the shadowed command-block registers.
// Assumes the producer updates every field from flip-flops.
`timescale 1ns/100ps
`default_nettype none

interface deb_shadow_if;
    logic [7:0] devctl;
    logic [7:0] devhead;
    logic [15:0] features;
    logic [15:0] count;
    logic [15:0] number;
    logic [15:0] cyl_lo;
    logic [15:0] cyl_hi;
    logic [7:0] cmd_code;
    logic cmd_issue;

    modport producer (
        output devctl, devhead, features, count, number, cyl_lo, cyl_hi,
        output cmd_code, cmd_issue
    );
    modport consumer (
        input devctl, devhead, features, count, number, cyl_lo, cyl_hi,
        input cmd_code, cmd_issue
    );
endinterface

`default_nettype wire

/* logic/deb_tf_shadow.sv */
// Shadow of the command-block registers, with current and previous bytes for the five 16-bit registers.
// Assumes one register write per cycle, synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module deb_tf_shadow (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tf_wr,
    input wire logic [2:0] tf_sel,
    input wire logic [7:0] tf_data,
    deb_shadow_if.producer sh
);
    logic [7:0] devctl_reg, devctl_next;
    logic [7:0] devhead_reg, devhead_next;
    logic [15:0] feat_reg, feat_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] num_reg, num_next;
    logic [15:0] cyl_lo_reg, cyl_lo_next;
    logic [15:0] cyl_hi_reg, cyl_hi_next;
    logic [7:0] cmd_reg, cmd_next;
    logic issue_reg, issue_next;

    // ------------------------------------------------------------------
    // Next state: a write to a 16-bit register pushes the old current byte into the high byte.
    // ------------------------------------------------------------------
    always_comb begin
        devctl_next = devctl_reg;
        devhead_next = devhead_reg;
        feat_next = feat_reg;
        cnt_next = cnt_reg;
        num_next = num_reg;
        cyl_lo_next = cyl_lo_reg;
        cyl_hi_next = cyl_hi_reg;
        cmd_next = cmd_reg;
        issue_next = 1'b0;
        if (tf_wr) begin
            unique case (deb_pkg::deb_tf_sel_t'(tf_sel))
                deb_pkg::DEB_TF_DEVCTL: devctl_next = tf_data;
                deb_pkg::DEB_TF_FEATURES: feat_next = {feat_reg[7:0], tf_data};
                deb_pkg::DEB_TF_COUNT: cnt_next = {cnt_reg[7:0], tf_data};
                deb_pkg::DEB_TF_NUMBER: num_next = {num_reg[7:0], tf_data};
                deb_pkg::DEB_TF_CYL_LO: cyl_lo_next = {cyl_lo_reg[7:0], tf_data};
                deb_pkg::DEB_TF_CYL_HI: cyl_hi_next = {cyl_hi_reg[7:0], tf_data};
                deb_pkg::DEB_TF_DEVHEAD: devhead_next = tf_data;
                deb_pkg::DEB_TF_COMMAND: begin
                    cmd_next = tf_data;
                    issue_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            devctl_reg <= 8'h00;
            devhead_reg <= 8'h00;
            feat_reg <= 16'h0000;
            cnt_reg <= 16'h0000;
            num_reg <= 16'h0000;
            cyl_lo_reg <= 16'h0000;
            cyl_hi_reg <= 16'h0000;
            cmd_reg <= 8'h00;
            issue_reg <= 1'b0;
        end else begin
            devctl_reg <= devctl_next;
            devhead_reg <= devhead_next;
            feat_reg <= feat_next;
            cnt_reg <= cnt_next;
            num_reg <= num_next;
            cyl_lo_reg <= cyl_lo_next;
            cyl_hi_reg <= cyl_hi_next;
            cmd_reg <= cmd_next;
            issue_reg <= issue_next;
        end
    end

    assign sh.devctl = devctl_reg;
    assign sh.devhead = devhead_reg;
    assign sh.features = feat_reg;
    assign sh.count = cnt_reg;
    assign sh.number = num_reg;
    assign sh.cyl_lo = cyl_lo_reg;
    assign sh.cyl_hi = cyl_hi_reg;
    assign sh.cmd_code = cmd_reg;
    assign sh.cmd_issue = issue_reg;
endmodule

`default_nettype wire

/* logic/deb_log_builder.sv */
// Builder of the log directory sector and the extended error log sector.
// Assumes error reports follow the command issue that they concern.
`timescale 1ns/100ps
`default_nettype none

module deb_log_builder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tf_wr,
    input wire logic [2:0] tf_sel,
    input wire logic [7:0] tf_data,
    input wire logic [7:0] power_state,
    input wire logic [31:0] power_on_ms,
    input wire logic [15:0] power_on_hours,
    input wire logic ncq_supported,
    input wire logic link_event_supported,
    input wire logic queue_mgmt_supported,
    input wire logic rebuild_supported,
    input wire logic err_report,
    input wire logic err_malformed,
    input wire logic [7:0] err_error,
    input wire logic [7:0] err_status,
    input wire logic [15:0] err_count_hob,
    input wire logic [15:0] err_number_hob,
    input wire logic [15:0] err_cyl_lo_hob,
    input wire logic [15:0] err_cyl_hi_hob,
    input wire logic [7:0] err_devhead,
    input wire logic rd_req,
    input wire logic [7:0] rd_log,
    input wire logic [8:0] rd_byte,
    output logic rd_valid,
    output logic rd_abort,
    output logic [7:0] rd_data,
    output logic [2:0] error_index,
    output logic [15:0] error_count
);
    deb_shadow_if sh ();

    deb_tf_shadow u_shadow (
        .clk(clk),
        .rst_n(rst_n),
        .tf_wr(tf_wr),
        .tf_sel(tf_sel),
        .tf_data(tf_data),
        .sh(sh)
    );

    deb_pkg::deb_cmd_snap_t hist_reg [deb_pkg::NUM_CMD_SNAPS];
    deb_pkg::deb_cmd_snap_t hist_next [deb_pkg::NUM_CMD_SNAPS];
    deb_pkg::deb_entry_t mem_reg [deb_pkg::NUM_ENTRIES];
    deb_pkg::deb_entry_t mem_next [deb_pkg::NUM_ENTRIES];
    deb_pkg::deb_entry_t entry_new;
    deb_pkg::deb_cmd_snap_t snap;
    logic [7:0] state_reg, state_next;
    logic [2:0] index_reg, index_next;
    logic [15:0] count_reg, count_next;
    logic [7:0] sum_reg, sum_next;
    logic [2:0] slot;
    logic rd_valid_reg, rd_valid_next;
    logic rd_abort_reg, rd_abort_next;
    logic [7:0] rd_data_reg, rd_data_next;

    function automatic logic [7:0] entry_sum(input deb_pkg::deb_entry_t e);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < deb_pkg::ENTRY_BYTES; i++) begin
            s = s + e[i];
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Command history and error capture
    // ------------------------------------------------------------------
    always_comb begin
        snap = {power_on_ms, 8'h00, sh.cmd_code, sh.devhead,
            sh.cyl_hi, sh.cyl_lo, sh.number, sh.count,
            sh.features, sh.devctl};
        hist_next = hist_reg;
        state_next = state_reg;
        if (sh.cmd_issue) begin
            for (int k = 0; k < deb_pkg::NUM_CMD_SNAPS - 1; k++) begin
                hist_next[k] = hist_reg[k+1];
            end
            hist_next[deb_pkg::NUM_CMD_SNAPS-1] = snap;
            state_next = power_state;
        end
    end

    always_comb begin
        entry_new = '0;
        for (int k = 0; k < deb_pkg::NUM_CMD_SNAPS; k++) begin
            entry_new[k*deb_pkg::CMD_SNAP_BYTES +: deb_pkg::CMD_SNAP_BYTES] =
                hist_reg[k];
        end
        entry_new[deb_pkg::ENTRY_BYTES-1:deb_pkg::ERR_SNAP_OFS] = {
            power_on_hours, state_reg, 152'h0, err_status,
            err_devhead, err_cyl_hi_hob, err_cyl_lo_hob,
            err_number_hob, err_count_hob, err_error, 8'h00};
    end

    always_comb begin
        mem_next = mem_reg;
        index_next = index_reg;
        count_next = count_reg;
        sum_next = sum_reg;
        slot = (index_reg == deb_pkg::MAX_INDEX) ? 3'h0 : index_reg;
        if (err_report && !err_malformed) begin
            mem_next[slot[1:0]] = entry_new;
            index_next = slot + 3'h1;
            sum_next = sum_reg + entry_sum(entry_new)
                - entry_sum(mem_reg[slot[1:0]]);
            if (count_reg != deb_pkg::ERR_COUNT_MAX) begin
                count_next = count_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte read port
    // ------------------------------------------------------------------
    function automatic logic [7:0] dir_count(
        input logic [7:0] addr,
        input logic [3:0] flags
    );
        logic [7:0] v;
        v = 8'h00;
        if (addr == deb_pkg::LOG_ERROR) begin
            v = deb_pkg::ERROR_LOG_SECTORS;
        end else if (addr >= deb_pkg::VENDOR_LOG_FIRST &&
                     addr <= deb_pkg::VENDOR_LOG_LAST) begin
            v = deb_pkg::VENDOR_LOG_SECTORS;
        end else if (addr == deb_pkg::LOG_NCQ) begin
            v = {7'h00, flags[0]};
        end else if (addr == deb_pkg::LOG_LINK_EVENT) begin
            v = {7'h00, flags[1]};
        end else if (addr == deb_pkg::LOG_QUEUE_MGMT) begin
            v = {7'h00, flags[2]};
        end else if (addr == deb_pkg::LOG_REBUILD) begin
            v = {7'h00, flags[3]};
        end
        return v;
    endfunction

    logic [3:0] flags;
    logic [7:0] dir_sum;
    logic [7:0] err_sum;
    logic [8:0] rel;
    logic [1:0] esel;

    always_comb begin
        flags = {rebuild_supported, queue_mgmt_supported,
                 link_event_supported, ncq_supported};
        // Vendor logs add 32 times 16, which is zero modulo 256.
        dir_sum = deb_pkg::DIR_VERSION[7:0] + deb_pkg::ERROR_LOG_SECTORS
            + {7'h00, flags[0]} + {7'h00, flags[1]}
            + {7'h00, flags[2]} + {7'h00, flags[3]};
        err_sum = deb_pkg::ERR_VERSION + {5'h00, index_reg}
            + count_reg[7:0] + count_reg[15:8] + sum_reg;
        if (rd_byte >= deb_pkg::OFS_ENTRY3) begin
            esel = 2'h3;
            rel = rd_byte - deb_pkg::OFS_ENTRY3;
        end else if (rd_byte >= deb_pkg::OFS_ENTRY2) begin
            esel = 2'h2;
            rel = rd_byte - deb_pkg::OFS_ENTRY2;
        end else if (rd_byte >= deb_pkg::OFS_ENTRY1) begin
            esel = 2'h1;
            rel = rd_byte - deb_pkg::OFS_ENTRY1;
        end else begin
            esel = 2'h0;
            rel = rd_byte - deb_pkg::OFS_ENTRY0;
        end
        rd_valid_next = rd_req;
        rd_abort_next = 1'b0;
        rd_data_next = 8'h00;
        if (rd_req) begin
            if (rd_log == deb_pkg::LOG_DIRECTORY) begin
                if (rd_byte == deb_pkg::OFS_CHECKSUM) begin
                    rd_data_next = 8'h00 - dir_sum;
                end else if (rd_byte[8:1] == 8'h00) begin
                    rd_data_next = rd_byte[0] ? deb_pkg::DIR_VERSION[15:8]
                        : deb_pkg::DIR_VERSION[7:0];
                end else if (!rd_byte[0]) begin
                    rd_data_next = dir_count(rd_byte[8:1], flags);
                end
            end else if (rd_log == deb_pkg::LOG_ERROR) begin
                if (rd_byte == deb_pkg::OFS_VERSION) begin
                    rd_data_next = deb_pkg::ERR_VERSION;
                end else if (rd_byte == deb_pkg::OFS_INDEX_LO) begin
                    rd_data_next = {5'h00, index_reg};
                end else if (rd_byte == deb_pkg::OFS_COUNT_LO) begin
                    rd_data_next = count_reg[7:0];
                end else if (rd_byte == deb_pkg::OFS_COUNT_HI) begin
                    rd_data_next = count_reg[15:8];
                end else if (rd_byte == deb_pkg::OFS_CHECKSUM) begin
                    rd_data_next = 8'h00 - err_sum;
                end else if (rd_byte >= deb_pkg::OFS_ENTRY0 &&
                             rd_byte < deb_pkg::OFS_COUNT_LO) begin
                    rd_data_next = mem_reg[esel][rel[6:0]];
                end
            end else begin
                rd_abort_next = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_reg <= '{default: '0};
            mem_reg <= '{default: '0};
            state_reg <= 8'h00;
            index_reg <= 3'h0;
            count_reg <= 16'h0000;
            sum_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            rd_abort_reg <= 1'b0;
            rd_data_reg <= 8'h00;
        end else begin
            hist_reg <= hist_next;
            mem_reg <= mem_next;
            state_reg <= state_next;
            index_reg <= index_next;
            count_reg <= count_next;
            sum_reg <= sum_next;
            rd_valid_reg <= rd_valid_next;
            rd_abort_reg <= rd_abort_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_valid = rd_valid_reg;
    assign rd_abort = rd_abort_reg;
    assign rd_data = rd_data_reg;
    assign error_index = index_reg;
    assign error_count = count_reg;
endmodule

`default_nettype wire

/* dv/deb_log_builder_checker.sv */
// Concurrent checks on the ports of the log builder.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module deb_log_builder_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic err_report,
    input wire logic err_malformed,
    input wire logic rd_req,
    input wire logic [7:0] rd_log,
    input wire logic [8:0] rd_byte,
    input wire logic rd_valid,
    input wire logic rd_abort,
    input wire logic [7:0] rd_data,
    input wire logic [2:0] error_index,
    input wire logic [15:0] error_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    property p_rd_answer;
        rd_req |=> rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no answer");
    property p_rd_quiet;
        !rd_req |=> !rd_valid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray answer");
    property p_abort;
        rd_req && rd_log != 8'h00 && rd_log != 8'h03
            |=> rd_abort && rd_data == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missing");
    property p_served;
        rd_req && (rd_log == 8'h00 || rd_log == 8'h03) |=> !rd_abort;
    endproperty
    a_served: assert property (p_served) else $error("log refused");
    property p_version;
        rd_req && (rd_log == 8'h00 || rd_log == 8'h03) && rd_byte == 9'h000
            |=> rd_data == 8'h01;
    endproperty
    a_version: assert property (p_version) else $error("bad version");
    property p_index_byte;
        rd_req && rd_log == 8'h03 && rd_byte == 9'h002
            |=> rd_data == {5'h00, $past(error_index)};
    endproperty
    a_index_byte: assert property (p_index_byte) else $error("index byte");

    // ------------------------------------------------------------------
    // Error index and count
    // ------------------------------------------------------------------
    property p_index_range;
        error_index <= 3'h4;
    endproperty
    a_index_range: assert property (p_index_range) else $error("index range");
    property p_index_next;
        err_report && !err_malformed |=> error_index ==
            ($past(error_index) == 3'h4 ? 3'h1 : $past(error_index) + 3'h1);
    endproperty
    a_index_next: assert property (p_index_next) else $error("ring step");
    property p_malformed;
        err_report && err_malformed |=> $stable(error_index)
            && $stable(error_count);
    endproperty
    a_malformed: assert property (p_malformed) else $error("logged bad");
    property p_count_step;
        err_report && !err_malformed && error_count != 16'hFFFF
            |=> error_count == $past(error_count) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step");
    property p_count_sat;
        error_count == 16'hFFFF |=> error_count == 16'hFFFF;
    endproperty
    a_count_sat: assert property (p_count_sat) else $error("count wrap");

    c_sat: cover property (error_count == 16'hFFFF);
    c_wrap: cover property (error_index == 3'h4 ##1 error_index == 3'h1);
    c_abort: cover property (rd_valid && rd_abort);
endmodule

bind deb_log_builder deb_log_builder_checker deb_log_builder_checker_i (
    .clk(clk), .rst_n(rst_n), .err_report(err_report),
    .err_malformed(err_malformed), .rd_req(rd_req), .rd_log(rd_log),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_abort(rd_abort),
    .rd_data(rd_data), .error_index(error_index), .error_count(error_count)
);

`default_nettype wire

/* dv/deb_host_model.sv */
// Host-side model that issues single-byte log reads.
// Assumes the builder answers one cycle after each taken request.
`timescale 1ns/100ps
`default_nettype none

module deb_host_model (
    input wire logic clk,
    output logic rd_req,
    output logic [7:0] rd_log,
    output logic [8:0] rd_byte,
    input wire logic rd_valid,
    input wire logic rd_abort,
    input wire logic [7:0] rd_data
);
    initial {rd_req, rd_log, rd_byte} = 18'h0_0000;

    // Released address lines show the inverse of the last request.
    task automatic read_byte(input logic [7:0] lg, input logic [8:0] ofs,
                             output logic [7:0] d, output logic ab);
        int n;
        @(posedge clk);
        rd_req <= 1'b1;
        rd_log <= lg;
        rd_byte <= ofs;
        @(posedge clk);
        rd_req <= 1'b0;
        rd_log <= ~lg;
        rd_byte <= ~ofs;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rd_valid !== 1'b1 && n < 4);
        d = rd_data;
        ab = rd_abort;
    endtask
endmodule

`default_nettype wire

/* dv/deb_log_builder_bench.sv */
// Self-checking bench for the log builder.
// Assumes the host model performs every read of the two sectors.
`timescale 1ns/100ps
`default_nettype none

`define DEB_CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
    n_mismatch++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end

module deb_log_builder_bench;
    logic clk, rst_n, tf_wr, err_report, err_malformed, rd_req;
    logic ncq, lnk, qm, rb, rd_valid, rd_abort;
    logic [2:0] tf_sel, error_index;
    logic [7:0] tf_data, power_state, err_error, err_status, err_devhead;
    logic [7:0] rd_log, rd_data;
    logic [8:0] rd_byte;
    logic [31:0] power_on_ms;
    logic [15:0] power_on_hours, c_hob, n_hob, l_hob, h_hob, error_count;
    logic [7:0] mem [512];
    int n_mismatch = 0;
    int checks = 0;

    deb_log_builder deb_log_builder_i (.clk(clk), .rst_n(rst_n),
        .tf_wr(tf_wr), .tf_sel(tf_sel), .tf_data(tf_data),
        .power_state(power_state), .power_on_ms(power_on_ms),
        .power_on_hours(power_on_hours), .ncq_supported(ncq),
        .link_event_supported(lnk), .queue_mgmt_supported(qm),
        .rebuild_supported(rb), .err_report(err_report),
        .err_malformed(err_malformed), .err_error(err_error),
        .err_status(err_status), .err_count_hob(c_hob),
        .err_number_hob(n_hob), .err_cyl_lo_hob(l_hob),
        .err_cyl_hi_hob(h_hob), .err_devhead(err_devhead),
        .rd_req(rd_req), .rd_log(rd_log), .rd_byte(rd_byte),
        .rd_valid(rd_valid), .rd_abort(rd_abort), .rd_data(rd_data),
        .error_index(error_index), .error_count(error_count));
    deb_host_model deb_host_model_i (.clk(clk), .rd_req(rd_req),
        .rd_log(rd_log), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .rd_abort(rd_abort), .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end

    task automatic tf(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        tf_wr <= 1'b1;
        tf_sel <= s;
        tf_data <= d;
        @(posedge clk);
        tf_wr <= 1'b0;
    endtask

    task automatic err(input logic mal);
        @(posedge clk);
        err_report <= 1'b1;
        err_malformed <= mal;
        @(posedge clk);
        err_report <= 1'b0;
        err_malformed <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_all(input logic [7:0] lg, output logic [7:0] sum);
        logic ab;
        sum = 8'h00;
        for (int i = 0; i < 512; i++) begin
            deb_host_model_i.read_byte(lg, 9'(i), mem[i], ab);
            sum += mem[i];
        end
    endtask

    task automatic chk_rd(input string nm, input logic [8:0] ofs,
                          input logic [7:0] ex);
        logic [7:0] d;
        logic ab;
        deb_host_model_i.read_byte(deb_pkg::LOG_ERROR, ofs, d, ab);
        `DEB_CHK(nm, ex, d)
    endtask

    function automatic logic [7:0] dir_exp(input int a, input logic [3:0] f);
        logic [7:0] lg;
        lg = 8'(a / 2);
        if (a == 0)
            return 8'h01;
        if (a % 2 == 1)
            return 8'h00;
        if (lg >= 8'h80 && lg <= 8'h9F)
            return 8'h10;
        case (lg)
            8'h03: return 8'h01;
            8'h10: return {7'h00, f[0]};
            8'h11: return {7'h00, f[1]};
            8'h12: return {7'h00, f[2]};
            8'h15: return {7'h00, f[3]};
            default: return 8'h00;
        endcase
    endfunction

    initial begin
        logic [7:0] d, s;
        logic ab;
        logic [3:0] f;
        logic [8:0] b;
        {rst_n, tf_wr, err_report, err_malformed, ncq, lnk, qm, rb} = 8'h00;
        {tf_sel, tf_data, power_state, err_error, err_status} = 35'h0;
        {err_devhead, power_on_ms, power_on_hours} = 56'h0;
        {c_hob, n_hob, l_hob, h_hob} = 64'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;

        // --------------------------------------------------------------
        // Directory with two patterns of support flags
        // --------------------------------------------------------------
        for (int p = 0; p < 2; p++) begin
            f = p == 0 ? 4'b0101 : 4'b1010;
            @(posedge clk);
            {rb, qm, lnk, ncq} <= f;
            rd_all(deb_pkg::LOG_DIRECTORY, s);
            for (int i = 0; i < 511; i++)
                `DEB_CHK("dir byte", dir_exp(i, f), mem[i])
            `DEB_CHK("dir sum", 8'h00, s)
        end
        $display("test directory done");

        // --------------------------------------------------------------
        // Empty error log, refused logs and a malformed failure
        // --------------------------------------------------------------
        rd_all(deb_pkg::LOG_ERROR, s);
        for (int i = 0; i < 511; i++)
            `DEB_CHK("err byte", i == 0 ? 8'h01 : 8'h00, mem[i])
        `DEB_CHK("err sum", 8'h00, s)
        deb_host_model_i.read_byte(8'h05, 9'h000, d, ab);
        `DEB_CHK("abort", 9'h100, {ab, d})
        deb_host_model_i.read_byte(8'h80, 9'h000, d, ab);
        `DEB_CHK("abort vendor", 9'h100, {ab, d})
        err(1'b1);
        `DEB_CHK("malformed", 19'h0, {error_index, error_count})
        $display("test empty log done");

        // --------------------------------------------------------------
        // Five logged errors walk the ring once round
        // --------------------------------------------------------------
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            power_state <= {4'h5, 4'(k)};
            power_on_ms <= 32'h1234_5600 + 32'(k);
            tf(3'h1, 8'h10 + 8'(k));
            tf(3'h1, 8'h20 + 8'(k));
            tf(3'h7, 8'hC0 + 8'(k));
            @(posedge clk);
            power_state <= 8'h0F;
            power_on_hours <= 16'h0100 + 16'(k);
            err_error <= 8'hE0 + 8'(k);
            err_status <= 8'h51;
            c_hob <= 16'hA0B0 + 16'(k);
            err(1'b0);
            b = 9'(4 + 124 * (k % 4));
            `DEB_CHK("index", 3'(k % 4 + 1), error_index)
            `DEB_CHK("count", 16'(k + 1), error_count)
            chk_rd("index byte", 9'h002, 8'(k % 4 + 1));
            chk_rd("command", b + 9'h054, 8'hC0 + 8'(k));
            chk_rd("feat lo", b + 9'h049, 8'h20 + 8'(k));
            chk_rd("feat hi", b + 9'h04A, 8'h10 + 8'(k));
            chk_rd("ms lsb", b + 9'h056, 8'h00 + 8'(k));
            chk_rd("ms msb", b + 9'h059, 8'h12);
            chk_rd("error", b + 9'h05B, 8'hE0 + 8'(k));
            chk_rd("hob lo", b + 9'h05C, 8'hB0 + 8'(k));
            chk_rd("hob hi", b + 9'h05D, 8'hA0);
            chk_rd("status", b + 9'h065, 8'h51);
            chk_rd("state", b + 9'h079, {4'h5, 4'(k)});
            chk_rd("hours", b + 9'h07A, 8'(k));
            if (k == 0)
                chk_rd("unwritten", 9'h0DB, 8'h00);
        end
        chk_rd("ring keeps", 9'h0D4, 8'hC1);
        rd_all(deb_pkg::LOG_ERROR, s);
        `DEB_CHK("log sum", 8'h00, s)
        $display("test error ring done");

        // --------------------------------------------------------------
        // Lifetime count saturates under a long burst
        // --------------------------------------------------------------
        @(posedge clk);
        err_report <= 1'b1;
        repeat (65540) @(posedge clk);
        err_report <= 1'b0;
        @(posedge clk);
        `DEB_CHK("saturated", 16'hFFFF, error_count)
        chk_rd("count lo", 9'h1F4, 8'hFF);
        chk_rd("count hi", 9'h1F5, 8'hFF);
        $display("test saturation done");
        finish_test();
    end
endmodule

`default_nettype wire
